// >>> nvw_ctrl.sv
// Nonvolatile write controller: data EEPROM byte writes, flash block writes,
// flash and EEPROM fetches, power-up lockout and external programming port.
// Assumes a classic Wishbone master on the register side and a core that honours stall_o.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module nvw_ctrl
  import nvw_pkg::*;
#(
  parameter int unsigned PWRT_US = PWRT_US_DEF,
  parameter int unsigned ERASE_US = ERASE_US_DEF,
  parameter int unsigned EE_WRITE_US = EE_WRITE_US_DEF,
  parameter int unsigned FLASH_AW = FLASH_AW_DEF
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic data_protect_fuse_n_i,
  input wire logic ext_rd_i,
  input wire logic ext_wr_i,
  input wire logic [7:0] ext_addr_i,
  input wire logic [7:0] ext_wdata_i,
  output logic [7:0] ext_rdata_o,
  output logic ext_refused_o,
  output logic stall_o,
  output logic irq_o
);
  // Arrays: data EEPROM, flash and the eight-word block buffer
  logic [7:0] ee_mem [EE_DEPTH];
  logic [WORD_W-1:0] fl_mem [2**FLASH_AW];
  logic [WORD_W-1:0] fl_buf [8];

  logic [7:0] loc_low_reg;
  logic [LOC_HIGH_W-1:0] loc_high_reg;
  logic [7:0] val_low_reg;
  logic [VAL_HIGH_W-1:0] val_high_reg;
  logic code_sel_reg, arm_reg, launch_reg, fault_reg;
  logic done_flag_reg, done_en_reg;
  logic [1:0] fetch_cnt_reg;
  logic [3:0] seq_reg;
  logic [FLASH_AW-1:0] op_addr_reg;
  logic [7:0] op_data_reg;
  logic pwrt_started_reg;
  nvw_state_e state_reg, state_next;
  logic unlocked, pwrt_run, op_busy, op_done;

  // Bus decode: ack one cycle after the request, effects at the ack edge
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_fire = bus_req && wb_ack_o;
  wire bus_wr = bus_fire && wb_we_i && wb_sel_i[0];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire hit_ctrl = (wb_adr_i == OFF_CTRL);
  wire hit_key = (wb_adr_i == OFF_KEY);
  wire hit_flags = (wb_adr_i == OFF_IRQ_FLAGS);
  wire ctrl_wr = bus_wr && hit_ctrl;
  wire key_wr = bus_wr && hit_key;

  // Launch qualification; the written select bit counts, as software sets both at once
  wire launch_req = ctrl_wr && wdat[BIT_LAUNCH];
  wire launch_ok = launch_req && arm_reg && unlocked && !launch_reg
    && (state_reg == ST_IDLE);
  wire pwrt_busy = !pwrt_started_reg || pwrt_run;
  wire ee_start = launch_ok && !wdat[BIT_CODE_SEL] && !pwrt_busy;
  wire pwrt_refused = launch_ok && !wdat[BIT_CODE_SEL] && pwrt_busy;
  wire fl_start = launch_ok && wdat[BIT_CODE_SEL];
  wire fl_last = (loc_low_reg[2:0] == BLOCK_LAST);
  wire fetch_go = ctrl_wr && wdat[BIT_FETCH] && (state_reg == ST_IDLE)
    && (fetch_cnt_reg == 2'h0);
  wire fetch_code_go = fetch_go && wdat[BIT_CODE_SEL];
  wire fetch_load = (fetch_cnt_reg == 2'h1);

  // Location words and flash write addressing over the sixteen-word erase block
  wire [FLASH_AW-1:0] fl_loc = FLASH_AW'({loc_high_reg, loc_low_reg});
  wire [WORD_W-1:0] fl_rd_word = fl_mem[fl_loc];
  wire [FLASH_AW-1:0] prog_addr = {op_addr_reg[FLASH_AW-1:4], seq_reg};
  wire prog_in_block = (seq_reg[3] == op_addr_reg[3]);
  wire [WORD_W-1:0] prog_word = prog_in_block ? fl_buf[seq_reg[2:0]] : FLASH_ERASED;
  wire prog_we = (state_reg == ST_FL_PROG);
  wire ee_done = (state_reg == ST_EE_WRITE) && op_done;
  wire fl_done = prog_we && (seq_reg == BLOCK16_LAST);
  wire setup_done = (state_reg == ST_FL_SETUP) && (seq_reg == FL_SETUP_LAST);
  wire op_end = ee_done || fl_done || setup_done;
  wire done_event = ee_done || fl_done;

  // External port: refused when protected; writes also dropped while an EEPROM byte write is in flight
  wire ext_protected = !data_protect_fuse_n_i;
  wire ext_wr_ok = ext_wr_i && !ext_protected && (state_reg != ST_EE_WRITE);

  // Register read view; unmapped offsets read zero
  wire [7:0] ctrl_view = {code_sel_reg, 3'h0, fault_reg, arm_reg, launch_reg,
    fetch_cnt_reg != 2'h0};
  wire [7:0] flags_view = 8'(done_flag_reg) << BIT_DONE;
  wire [7:0] en_view = 8'(done_en_reg) << BIT_DONE;
  wire [7:0] rd_mux =
    hit_ctrl ? ctrl_view :
    (wb_adr_i == OFF_LOC_LOW) ? loc_low_reg :
    (wb_adr_i == OFF_LOC_HIGH) ? 8'(loc_high_reg) :
    (wb_adr_i == OFF_VAL_LOW) ? val_low_reg :
    (wb_adr_i == OFF_VAL_HIGH) ? 8'(val_high_reg) :
    (wb_adr_i == OFF_IRQ_EN) ? en_view :
    hit_flags ? flags_view : 8'h00;

  // Unlock keys; every access other than a key write disarms the sequence
  nvw_unlock u_unlock (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .key_wr_i(key_wr),
    .key_i(wdat),
    .clear_i(bus_fire && !key_wr),
    .unlocked_o(unlocked)
  );

  // Power-up lockout timer, started once after reset release
  nvw_us_timer u_pwrt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(!pwrt_started_reg),
    .count_i(TIMER_W'(PWRT_US)),
    .busy_o(pwrt_run),
    .done_o()
  );

  // Shared timer for the EEPROM byte write and the flash erase
  nvw_us_timer u_op_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(ee_start || (fl_start && fl_last)),
    .count_i(ee_start ? TIMER_W'(EE_WRITE_US) : TIMER_W'(ERASE_US)),
    .busy_o(op_busy),
    .done_o(op_done)
  );

  // Write sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ee_start) begin
          state_next = ST_EE_WRITE;
        end else if (fl_start) begin
          state_next = fl_last ? ST_FL_ERASE : ST_FL_SETUP;
        end
      end
      ST_EE_WRITE: if (op_done) state_next = ST_IDLE;
      ST_FL_SETUP: if (setup_done) state_next = ST_IDLE;
      ST_FL_ERASE: if (op_done) state_next = ST_FL_PROG;
      ST_FL_PROG: if (fl_done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      seq_reg <= 4'h0;
      op_addr_reg <= '0;
      op_data_reg <= 8'h00;
      pwrt_started_reg <= 1'b0;
      stall_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      pwrt_started_reg <= 1'b1;
      seq_reg <= (state_next != state_reg) ? 4'h0 : seq_reg + 4'h1;
      stall_o <= (state_next == ST_FL_ERASE) || (state_next == ST_FL_PROG);
      if (ee_start || fl_start) begin
        op_addr_reg <= fl_loc;
        op_data_reg <= val_low_reg;
      end
    end
  end

  // Arrays carry no reset; one write port each
  always_ff @(posedge clock_i) begin
    if (fl_start) begin
      fl_buf[loc_low_reg[2:0]] <= {val_high_reg, val_low_reg};
    end
    if (prog_we) begin
      fl_mem[prog_addr] <= prog_word;
    end
    if (ee_done) begin
      ee_mem[op_addr_reg[7:0]] <= op_data_reg;
    end else if (ext_wr_ok) begin
      ee_mem[ext_addr_i] <= ext_wdata_i;
    end
  end

  // Control bits; launch cannot be cleared by software, only by the end of a cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      code_sel_reg <= 1'b0;
      arm_reg <= 1'b0;
      launch_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        code_sel_reg <= wdat[BIT_CODE_SEL];
        arm_reg <= wdat[BIT_ARM];
      end
      if (launch_ok && !pwrt_refused) begin
        launch_reg <= 1'b1;
      end else if (op_end) begin
        launch_reg <= 1'b0;
      end
      if (pwrt_refused) begin
        fault_reg <= 1'b1;
      end else if (ctrl_wr && !wdat[BIT_FAULT]) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Location and value registers; fetch results overwrite the value pair, an EEPROM fetch the low byte only
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      loc_low_reg <= 8'h00;
      loc_high_reg <= '0;
      val_low_reg <= 8'h00;
      val_high_reg <= '0;
      fetch_cnt_reg <= 2'h0;
    end else begin
      if (bus_wr && wb_adr_i == OFF_LOC_LOW) loc_low_reg <= wdat;
      if (bus_wr && wb_adr_i == OFF_LOC_HIGH) loc_high_reg <= wdat[LOC_HIGH_W-1:0];
      if (fetch_go && !wdat[BIT_CODE_SEL]) begin
        val_low_reg <= ee_mem[loc_low_reg];
      end else if (fetch_load) begin
        val_low_reg <= fl_rd_word[7:0];
        val_high_reg <= fl_rd_word[WORD_W-1:8];
      end else begin
        if (bus_wr && wb_adr_i == OFF_VAL_LOW) val_low_reg <= wdat;
        if (bus_wr && wb_adr_i == OFF_VAL_HIGH) val_high_reg <= wdat[VAL_HIGH_W-1:0];
      end
      if (fetch_code_go) begin
        fetch_cnt_reg <= FETCH_LATENCY;
      end else if (fetch_cnt_reg != 2'h0) begin
        fetch_cnt_reg <= fetch_cnt_reg - 2'h1;
      end
    end
  end

  // Done flag: set wins over the write-one clear
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      done_flag_reg <= 1'b0;
      done_en_reg <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (done_event) begin
        done_flag_reg <= 1'b1;
      end else if (bus_wr && hit_flags && wdat[BIT_DONE]) begin
        done_flag_reg <= 1'b0;
      end
      if (bus_wr && wb_adr_i == OFF_IRQ_EN) done_en_reg <= wdat[BIT_DONE];
      irq_o <= (done_flag_reg || done_event) && done_en_reg;
    end
  end

  // Bus answer and external port outputs
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ext_rdata_o <= 8'h00;
      ext_refused_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_mux};
      ext_refused_o <= (ext_rd_i || ext_wr_i) && ext_protected;
      ext_rdata_o <= (ext_rd_i && !ext_protected) ? ee_mem[ext_addr_i] : 8'h00;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  arm_after_reset_a: assert property ($past(!resetn_i) |-> !arm_reg)
    else $error("arm bit set right after reset");
  pwrt_lockout_a: assert property (pwrt_busy && launch_req |=> state_reg != ST_EE_WRITE)
    else $error("EEPROM write started during power-up lockout");
  start_needs_key_a: assert property (
    state_reg == ST_IDLE && state_next != ST_IDLE |-> unlocked && arm_reg)
    else $error("write started without arm and keys");
  fuse_refuse_a: assert property (ext_rd_i && !data_protect_fuse_n_i
    |=> ext_refused_o && ext_rdata_o == 8'h00) else $error("protected data leaked");
  done_sets_a: assert property (ee_done |=> done_flag_reg && !launch_reg)
    else $error("write end did not set done and clear launch");
  unarmed_ignore_a: assert property (launch_req && !arm_reg && !launch_reg
    |=> !launch_reg) else $error("launch accepted while unarmed");
  block_stall_a: assert property (fl_start && fl_last |=>
    (stall_o && state_reg == ST_FL_ERASE && op_busy)[*2])
    else $error("block write did not stall the core");
  prog_span_a: assert property ($rose(prog_we) |-> (prog_we && stall_o)[*8])
    else $error("block programming cut short");
  fetch_timing_a: assert property (fetch_code_go |=> fetch_cnt_reg == 2'h2
    ##1 fetch_load ##1 val_low_reg == $past(fl_rd_word[7:0]))
    else $error("code fetch result late or wrong");

  ee_write_c: cover property (ee_done);
  block_write_c: cover property (fl_start && fl_last);
  code_fetch_c: cover property (fetch_code_go);
  ext_refused_c: cover property (ext_refused_o);

endmodule : nvw_ctrl

// >>> nvw_pkg.sv
// Constants, register map and state types of the nonvolatile write controller.
// Assumes a single 200 MHz core clock and an 8-bit register view in the low data lane.
package nvw_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned US_CYCLES = 1000000 / CLK_PERIOD_PS;
  localparam int unsigned PWRT_MS = 64;
  localparam int unsigned PWRT_US_DEF = PWRT_MS * 1000;
  localparam int unsigned ERASE_MS = 4;
  localparam int unsigned ERASE_US_DEF = ERASE_MS * 1000;
  localparam int unsigned EE_WRITE_MS = 4;
  localparam int unsigned EE_WRITE_US_DEF = EE_WRITE_MS * 1000;
  localparam int unsigned TIMER_W = 20;

  // Sequencing counts
  localparam logic [1:0] FETCH_LATENCY = 2'h2;
  localparam logic [3:0] FL_SETUP_LAST = 4'h1;
  localparam logic [3:0] BLOCK16_LAST = 4'hF;
  localparam logic [2:0] BLOCK_LAST = 3'h7;

  // Array shapes
  localparam int unsigned FLASH_AW_DEF = 13;
  localparam int unsigned EE_DEPTH = 256;
  localparam int unsigned LOC_HIGH_W = 5;
  localparam int unsigned VAL_HIGH_W = 6;
  localparam int unsigned WORD_W = 14;
  localparam logic [13:0] FLASH_ERASED = 14'h3FFF;

  // Register byte offsets
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY = 8'h04;
  localparam logic [7:0] OFF_LOC_LOW = 8'h08;
  localparam logic [7:0] OFF_LOC_HIGH = 8'h0C;
  localparam logic [7:0] OFF_VAL_LOW = 8'h10;
  localparam logic [7:0] OFF_VAL_HIGH = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h1C;

  // Control register fields and the done bit of the interrupt registers
  localparam int unsigned BIT_FETCH = 0;
  localparam int unsigned BIT_LAUNCH = 1;
  localparam int unsigned BIT_ARM = 2;
  localparam int unsigned BIT_FAULT = 3;
  localparam int unsigned BIT_CODE_SEL = 7;
  localparam int unsigned BIT_DONE = 4;

  // Unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  typedef enum logic [1:0] {KEY_WAIT_FIRST, KEY_WAIT_SECOND, KEY_OPEN} nvw_key_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EE_WRITE, ST_FL_SETUP, ST_FL_ERASE, ST_FL_PROG
  } nvw_state_e;

endpackage : nvw_pkg

// >>> nvw_unlock.sv
// Unlock key detector: first key, second key, then one launch may pass.
// Assumes clear_i pulses on every register access that is not a key write.
`timescale 1ns/1ps
module nvw_unlock
  import nvw_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_i,
  input wire logic clear_i,
  output logic unlocked_o
);
  nvw_key_e key_reg;
  nvw_key_e key_next;

  // Any stray access or wrong key drops back to the start
  always_comb begin
    key_next = KEY_WAIT_FIRST;
    if (clear_i) begin
      key_next = KEY_WAIT_FIRST;
    end else if (!key_wr_i) begin
      key_next = key_reg;
    end else begin
      case (key_reg)
        KEY_WAIT_FIRST: begin
          key_next = (key_i == KEY_FIRST) ? KEY_WAIT_SECOND : KEY_WAIT_FIRST;
        end
        KEY_WAIT_SECOND: begin
          key_next = (key_i == KEY_SECOND) ? KEY_OPEN : KEY_WAIT_FIRST;
        end
        default: key_next = KEY_WAIT_FIRST;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      key_reg <= KEY_WAIT_FIRST;
    end else begin
      key_reg <= key_next;
    end
  end

  assign unlocked_o = (key_reg == KEY_OPEN);

  stray_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    clear_i |=> !unlocked_o) else $error("unlock survived a stray access");
  key_order_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(unlocked_o) |-> $past(key_wr_i && key_i == KEY_SECOND)
      && $past(key_reg == KEY_WAIT_SECOND)) else $error("unlock without key pair");

endmodule : nvw_unlock

// >>> nvw_us_timer.sv
// Microsecond timer: a cycle divider makes a 1 us enable, a counter counts them.
// Assumes start_i is a one-cycle pulse; a start while busy restarts the count.
`timescale 1ns/1ps
module nvw_us_timer
  import nvw_pkg::*;
#(
  parameter int unsigned DIV = US_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [TIMER_W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] div_reg;
  logic [TIMER_W-1:0] left_reg;
  wire tick = busy_o && (div_reg == DIV_LAST);
  wire last_tick = tick && (left_reg <= TIMER_W'(1));

  // Divider only runs while busy, so every count starts on a clean tick
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      div_reg <= '0;
      left_reg <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last_tick && !start_i;
      if (start_i) begin
        busy_o <= 1'b1;
        left_reg <= count_i;
        div_reg <= '0;
      end else if (busy_o) begin
        div_reg <= tick ? '0 : div_reg + DW'(1);
        if (tick) begin
          left_reg <= left_reg - TIMER_W'(1);
        end
        if (last_tick) begin
          busy_o <= 1'b0;
        end
      end
    end
  end

endmodule : nvw_us_timer

// >>> tb_top.sv
// Self-checking bench for the nonvolatile write controller, register side over Wishbone.
// Assumes nvw_ctrl with its own assertions and shortened timer parameters.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top
  import nvw_pkg::*;
;
  logic clock_i;
  logic resetn_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o;
  logic fuse_n, ext_rd_i, ext_wr_i;
  logic [7:0] ext_addr_i, ext_wdata_i, ext_rdata_o;
  logic ext_refused_o, stall_o, irq_o;
  int mismatches = 0;
  int checks = 0;
  int i;

  // Short timers: lockout 400 cycles, EEPROM write and erase 200 cycles each
  nvw_ctrl #(.PWRT_US(2), .ERASE_US(1), .EE_WRITE_US(1), .FLASH_AW(13)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .data_protect_fuse_n_i(fuse_n),
    .ext_rd_i(ext_rd_i), .ext_wr_i(ext_wr_i), .ext_addr_i(ext_addr_i),
    .ext_wdata_i(ext_wdata_i), .ext_rdata_o(ext_rdata_o), .ext_refused_o(ext_refused_o),
    .stall_o(stall_o), .irq_o(irq_o));

  // 200 MHz core clock
  initial begin
    clock_i = 1'h0;
    forever #2.5 clock_i = ~clock_i;
  end

  task conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Classic single cycle; request held until ack is sampled high
  task wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat,
               output logic [31:0] q);
    int n;
    @(posedge clock_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    if (n >= 50) begin
      mismatches++;
      $display("unexpected at %0t: no ack got %0h expected %0h", $time, 1'h0, 1'h1);
    end
  endtask : wb_xfer

  task wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] q;
    wb_xfer(1'h1, adr, dat, q);
  endtask : wr

  task rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] q;
    wb_xfer(1'h0, adr, 8'h00, q);
    `CHK(q, {24'h000000, exp})
  endtask : rd_chk

  // Keys, then control write in three back-to-back accesses
  task launch_seq(input logic [7:0] ctl);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_CTRL, ctl);
  endtask : launch_seq

  // Poll the launch bit; bounded so a stuck write shows as a mismatch
  task wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb_xfer(1'h0, OFF_CTRL, 8'h00, q);
      n++;
    end while (q[BIT_LAUNCH] !== 1'h0 && n < 400);
    `CHK(q[BIT_LAUNCH], 1'h0)
  endtask : wait_idle

  // One external programmer request; outputs settle one cycle later
  task ext_op(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    ext_rd_i <= r;
    ext_wr_i <= w;
    ext_addr_i <= a;
    ext_wdata_i <= d;
    @(posedge clock_i);
    ext_rd_i <= 1'h0;
    ext_wr_i <= 1'h0;
    #1;
  endtask : ext_op

  // Watchdog well beyond the expected 8000 ns
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    resetn_i = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_rd_i, ext_wr_i} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    ext_addr_i = 8'h00;
    ext_wdata_i = 8'h00;
    fuse_n = 1'h1;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'h1;
    rd_chk(OFF_CTRL, 8'h00);
    // EEPROM launch inside the power-up lockout is dropped and flagged
    wr(OFF_CTRL, 8'h04);
    launch_seq(8'h06);
    rd_chk(OFF_CTRL, 8'h0C);
    rd_chk(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_CTRL, 8'h00);
    repeat (450) @(posedge clock_i);
    // Unarmed launch, broken key sequence, reversed keys
    launch_seq(8'h02);
    rd_chk(OFF_CTRL, 8'h00);
    wr(OFF_LOC_LOW, 8'h10);
    wr(OFF_VAL_LOW, 8'hA5);
    wr(OFF_CTRL, 8'h04);
    wr(OFF_KEY, KEY_FIRST);
    rd_chk(OFF_LOC_LOW, 8'h10);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_CTRL, 8'h06);
    rd_chk(OFF_CTRL, 8'h04);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_CTRL, 8'h06);
    rd_chk(OFF_CTRL, 8'h04);
    // Field widths, write-only key port, unmapped offset
    wr(OFF_LOC_HIGH, 8'hFF);
    rd_chk(OFF_LOC_HIGH, 8'h1F);
    wr(OFF_VAL_HIGH, 8'hFF);
    rd_chk(OFF_VAL_HIGH, 8'h3F);
    rd_chk(OFF_KEY, 8'h00);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    // Proper EEPROM write with interrupt raised, masked and cleared
    wr(OFF_IRQ_EN, 8'h10);
    launch_seq(8'h06);
    rd_chk(OFF_CTRL, 8'h06);
    wait_idle();
    rd_chk(OFF_CTRL, 8'h04);
    rd_chk(OFF_IRQ_FLAGS, 8'h10);
    `CHK(irq_o, 1'h1)
    wr(OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge clock_i);
    `CHK(irq_o, 1'h0)
    wr(OFF_IRQ_EN, 8'h10);
    repeat (2) @(posedge clock_i);
    `CHK(irq_o, 1'h1)
    wr(OFF_IRQ_FLAGS, 8'h10);
    rd_chk(OFF_IRQ_FLAGS, 8'h00);
    `CHK(irq_o, 1'h0)
    // Read back the byte just written
    wr(OFF_VAL_LOW, 8'h00);
    wr(OFF_CTRL, 8'h01);
    rd_chk(OFF_VAL_LOW, 8'hA5);
    // External port open, then refused under protection
    ext_op(1'h1, 1'h0, 8'h10, 8'h00);
    `CHK({ext_refused_o, ext_rdata_o}, 9'h0A5)
    ext_op(1'h0, 1'h1, 8'h20, 8'h5A);
    fuse_n <= 1'h0;
    ext_op(1'h1, 1'h0, 8'h10, 8'h00);
    `CHK({ext_refused_o, ext_rdata_o}, 9'h100)
    ext_op(1'h0, 1'h1, 8'h20, 8'hFF);
    `CHK(ext_refused_o, 1'h1)
    wr(OFF_LOC_LOW, 8'h20);
    wr(OFF_CTRL, 8'h01);
    rd_chk(OFF_VAL_LOW, 8'h5A);
    // Refresh the byte from the core while protected; the core keeps write access
    wr(OFF_CTRL, 8'h04);
    launch_seq(8'h06);
    wait_idle();
    rd_chk(OFF_IRQ_FLAGS, 8'h10);
    wr(OFF_IRQ_FLAGS, 8'h10);
    wr(OFF_VAL_LOW, 8'h00);
    wr(OFF_CTRL, 8'h01);
    rd_chk(OFF_VAL_LOW, 8'h5A);
    fuse_n <= 1'h1;
    // Flash block of eight words at an aligned start
    wr(OFF_LOC_HIGH, 8'h01);
    for (i = 0; i < 8; i++) begin
      wr(OFF_LOC_LOW, 8'h08 + 8'(i));
      wr(OFF_VAL_LOW, 8'hC0 + 8'(i));
      wr(OFF_VAL_HIGH, 8'h20 + 8'(i));
      wr(OFF_CTRL, 8'h84);
      launch_seq(8'h86);
      @(posedge clock_i);
    end
    i = 0;
    while (stall_o !== 1'h1 && i < 5) begin
      @(posedge clock_i);
      i++;
    end
    `CHK(stall_o, 1'h1)
    i = 0;
    while (stall_o !== 1'h0 && i < 600) begin
      @(posedge clock_i);
      i++;
    end
    `CHK(stall_o, 1'h0)
    rd_chk(OFF_CTRL, 8'h84);
    rd_chk(OFF_IRQ_FLAGS, 8'h10);
    wr(OFF_IRQ_FLAGS, 8'h10);
    // Fetch every programmed word and one erased word of the other half
    for (i = 0; i < 8; i++) begin
      wr(OFF_LOC_LOW, 8'h08 + 8'(i));
      wr(OFF_CTRL, 8'h81);
      // Two idle cycles stand for the core's two slots after a code fetch
      repeat (2) @(posedge clock_i);
      rd_chk(OFF_VAL_LOW, 8'hC0 + 8'(i));
      rd_chk(OFF_VAL_HIGH, 8'h20 + 8'(i));
    end
    wr(OFF_LOC_LOW, 8'h03);
    wr(OFF_CTRL, 8'h81);
    repeat (2) @(posedge clock_i);
    rd_chk(OFF_VAL_LOW, 8'hFF);
    rd_chk(OFF_VAL_HIGH, 8'h3F);
    conclude();
  end
endmodule : tb_top
